//--- src/afb_ctrl.sv
// host controller for an asynchronous word-wide flash bus, Avalon-MM slave
//
// Contract
// - command writes may be controlled by chip select or by write strobe
// - active write pulse lasts at least 50 ns
// - inactive interval between write pulses lasts at least 20 ns
// - wait 150 ns after reset release before starting a write
// - hold reset low at least 100 ns at power-up
// - keep program supply up until status shows no error bits
// - output enable may lag chip select without lengthening access
// - wait 30 ns after write strobe rises before asserting output enable
`timescale 1ns/1ps
module afb_ctrl
	import afb_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	input  wire logic [BUS_AW-1:0] i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	output logic                   o_irq,
	output logic                   o_flash_ce_n,
	output logic                   o_flash_oe_n,
	output logic                   o_flash_we_n,
	output logic                   o_flash_rst_n,
	output logic                   o_flash_vpp_en,
	output logic      [ADDR_W-1:0] o_flash_addr,
	input  wire logic [DATA_W-1:0] i_flash_dq,
	output logic      [DATA_W-1:0] o_flash_dq,
	output logic                   o_flash_dq_oe
);
	typedef struct packed {
		afb_state_t        st;
		logic              ack;
		logic [31:0]       rdata_bus;
		logic              cfg_ce_ctrl;
		logic              cfg_vpp_req;
		logic              cfg_query;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] status_read_value;
		logic              poll;
		logic              ready_flag;
		logic [ERR_W-1:0]  operation_error_bits;
		logic              op_run;
		logic              vpp_hold;
		logic [IRQ_W-1:0]  irq_stat;
		logic [IRQ_W-1:0]  irq_mask;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              rst_n;
		logic              dq_oe;
		logic              vpp_en;
	} afb_main_t;

	localparam afb_main_t RESET_VAL = '{
		st: ST_BOOT, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, default: '0
	};

	afb_main_t         s;
	afb_main_t         next_s;
	logic [1:0]        rst_pipe;
	logic              rstn;
	logic [DATA_W-1:0] dq_sync;
	logic              acc;
	logic              take;
	logic              wr_ctrl;
	logic              go_read;
	logic              go_write;
	logic              go_poll;
	logic              go_reset;
	logic [IRQ_W-1:0]  irq_set;
	logic [31:0]       stat_word;
	logic              other_low;
	logic              ctl_low;

	afb_tmr_if #(.W(TMR_W)) tmr ();

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rstn = rst_pipe[1];

	afb_sync #(.W(DATA_W)) u_dq_sync (
		.i_clk  (i_clk),
		.i_rstn (rstn),
		.i_d    (i_flash_dq),
		.o_q    (dq_sync)
	);

	afb_timer u_timer (
		.i_clk  (i_clk),
		.i_rstn (rstn),
		.t      (tmr.tmr)
	);

	always_comb begin
		stat_word                                    = '0;
		stat_word[STAT_BUSY]                         = (s.st != ST_IDLE);
		stat_word[STAT_READY]                        = s.ready_flag;
		stat_word[STAT_VPP]                          = s.vpp_en;
		stat_word[STAT_OPRUN]                        = s.op_run;
		stat_word[STAT_ERR_LO +: ERR_W]              = s.operation_error_bits;
	end

	always_comb begin
		next_s    = s;
		tmr.load  = 1'b0;
		tmr.value = '0;
		irq_set   = '0;

		// one wait cycle per access, answer on the second
		acc        = (i_avs_read | i_avs_write) & ~s.ack;
		next_s.ack = acc;
		take       = i_avs_write & s.ack;
		wr_ctrl    = take && (i_avs_address == REG_CTRL);
		go_read    = wr_ctrl && i_avs_writedata[CTRL_GO_READ];
		go_write   = wr_ctrl && i_avs_writedata[CTRL_GO_WRITE];
		go_poll    = wr_ctrl && i_avs_writedata[CTRL_GO_POLL];
		go_reset   = wr_ctrl && i_avs_writedata[CTRL_GO_RESET];

		if (acc && i_avs_read) begin
			case (i_avs_address)
				REG_CTRL: begin
					next_s.rdata_bus = '0;
					next_s.rdata_bus[CTRL_CE_CTRL] = s.cfg_ce_ctrl;
					next_s.rdata_bus[CTRL_VPP_REQ] = s.cfg_vpp_req;
					next_s.rdata_bus[CTRL_QUERY]   = s.cfg_query;
				end
				REG_ADDR:     next_s.rdata_bus = 32'(s.addr);
				REG_WDATA:    next_s.rdata_bus = 32'(s.wdata);
				REG_RDATA:    next_s.rdata_bus = 32'(s.status_read_value);
				REG_STATUS:   next_s.rdata_bus = stat_word;
				REG_IRQ_STAT: next_s.rdata_bus = 32'(s.irq_stat);
				REG_IRQ_MASK: next_s.rdata_bus = 32'(s.irq_mask);
				default:      next_s.rdata_bus = '0;
			endcase
		end

		// setup registers change only while idle so a transfer sees stable values
		if (take && (s.st == ST_IDLE)) begin
			case (i_avs_address)
				REG_CTRL: begin
					next_s.cfg_ce_ctrl = i_avs_writedata[CTRL_CE_CTRL];
					next_s.cfg_vpp_req = i_avs_writedata[CTRL_VPP_REQ];
					next_s.cfg_query   = i_avs_writedata[CTRL_QUERY];
					if (i_avs_writedata[CTRL_VPP_REL]) begin
						next_s.vpp_hold = 1'b0;
					end
				end
				REG_ADDR:  next_s.addr  = i_avs_writedata[ADDR_W-1:0];
				REG_WDATA: next_s.wdata = i_avs_writedata[DATA_W-1:0];
				default: begin
				end
			endcase
		end
		if (take && (i_avs_address == REG_IRQ_MASK)) begin
			next_s.irq_mask = i_avs_writedata[IRQ_W-1:0];
		end
		if (take && (i_avs_address == REG_IRQ_STAT)) begin
			next_s.irq_stat = s.irq_stat & ~i_avs_writedata[IRQ_W-1:0];
		end

		case (s.st)
			ST_BOOT: begin
				next_s.st = ST_RST_LOW;
				tmr.load  = 1'b1;
				tmr.value = C_PLPH - TMR_ONE;
			end
			ST_RST_LOW: begin
				if (tmr.expired) begin
					next_s.st = ST_RST_REC;
					tmr.load  = 1'b1;
					tmr.value = C_RSTREC - TMR_ONE;
				end
			end
			ST_RST_REC: begin
				if (tmr.expired) begin
					next_s.st = ST_IDLE;
					irq_set[IRQ_DONE] = 1'b1;
				end
			end
			ST_IDLE: begin
				if (go_read) begin
					next_s.st   = ST_RD;
					next_s.poll = 1'b0;
					tmr.load    = 1'b1;
					tmr.value   = C_RD - TMR_ONE;
				end else if (go_write) begin
					next_s.st = ST_WR_SETUP;
					tmr.load  = 1'b1;
					tmr.value = C_SETUP - TMR_ONE;
				end else if (go_poll) begin
					// wait for ready flag to drop
					next_s.st   = ST_POLL_WT;
					next_s.poll = 1'b1;
					tmr.load    = 1'b1;
					tmr.value   = (s.cfg_query ? C_RDY_QY : C_RDY_OP) - TMR_ONE;
				end
			end
			ST_WR_SETUP: begin
				if (tmr.expired) begin
					next_s.st = ST_WR_PULSE;
					tmr.load  = 1'b1;
					tmr.value = C_WP - TMR_ONE;
				end
			end
			ST_WR_PULSE: begin
				if (tmr.expired) begin
					next_s.st = ST_WR_END;
					tmr.load  = 1'b1;
					tmr.value = C_HOLD - TMR_ONE;
				end
			end
			ST_WR_END: begin
				if (tmr.expired) begin
					next_s.st = ST_WR_REC;
					tmr.load  = 1'b1;
					tmr.value = C_WREC - TMR_ONE;
					if (s.cfg_vpp_req) begin
						next_s.op_run   = 1'b1;
						next_s.vpp_hold = 1'b1;
					end
				end
			end
			ST_WR_REC: begin
				if (tmr.expired) begin
					next_s.st = ST_IDLE;
					irq_set[IRQ_DONE] = 1'b1;
				end
			end
			ST_POLL_WT: begin
				if (tmr.expired) begin
					// status read uses array read timing
					next_s.st = ST_RD;
					tmr.load  = 1'b1;
					tmr.value = C_RD - TMR_ONE;
				end
			end
			ST_RD: begin
				if (tmr.expired) begin
					next_s.status_read_value = dq_sync;
					if (s.poll) begin
						next_s.ready_flag           = dq_sync[READY_BIT];
						next_s.operation_error_bits = {dq_sync[ERR_B3], dq_sync[ERR_B2],
						                               dq_sync[ERR_B1], dq_sync[ERR_B0]};
					end
					next_s.st = ST_RD_GAP;
					tmr.load  = 1'b1;
					tmr.value = C_HIZ - TMR_ONE;
				end
			end
			ST_RD_GAP: begin
				if (tmr.expired) begin
					if (s.poll && !s.ready_flag) begin
						next_s.st = ST_RD;
						tmr.load  = 1'b1;
						tmr.value = C_RD - TMR_ONE;
					end else begin
						next_s.st = ST_IDLE;
						irq_set[IRQ_DONE] = 1'b1;
						if (s.poll) begin
							next_s.op_run = 1'b0;
							if (s.operation_error_bits == '0) begin
								next_s.vpp_hold = 1'b0;
							end else begin
								irq_set[IRQ_ERR] = 1'b1;
							end
						end
					end
				end
			end
			default: begin
				next_s.st = ST_BOOT;
			end
		endcase

		// reset command wins over any transfer in progress
		if (go_reset && (s.st != ST_BOOT) && (s.st != ST_RST_LOW)) begin
			// long hold aborts a running operation
			next_s.st       = ST_RST_LOW;
			tmr.load        = 1'b1;
			tmr.value       = (s.op_run ? C_ABORT : C_PLPH) - TMR_ONE;
			next_s.op_run   = 1'b0;
			next_s.vpp_hold = 1'b0;
		end

		// set wins over a clear in the same cycle
		next_s.irq_stat = next_s.irq_stat | irq_set;

		// pins follow the next state so they leave flops
		other_low = (next_s.st == ST_WR_SETUP) || (next_s.st == ST_WR_PULSE) ||
		            (next_s.st == ST_WR_END);
		ctl_low   = (next_s.st == ST_WR_PULSE);
		// controlling strobe falls last and rises first
		if (next_s.cfg_ce_ctrl) begin
			next_s.ce_n = ~ctl_low & (next_s.st != ST_RD);
			next_s.we_n = ~other_low;
		end else begin
			next_s.ce_n = ~other_low & (next_s.st != ST_RD);
			next_s.we_n = ~ctl_low;
		end
		// output enable falls together with chip select
		next_s.oe_n   = (next_s.st != ST_RD);
		next_s.dq_oe  = other_low;
		next_s.rst_n  = (next_s.st != ST_BOOT) && (next_s.st != ST_RST_LOW);
		next_s.vpp_en = next_s.cfg_vpp_req | next_s.vpp_hold;
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			s <= RESET_VAL;
		end else begin
			s <= next_s;
		end
	end

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~s.ack;
	assign o_avs_readdata    = s.rdata_bus;
	assign o_irq             = |(s.irq_stat & s.irq_mask);
	assign o_flash_ce_n      = s.ce_n;
	assign o_flash_oe_n      = s.oe_n;
	assign o_flash_we_n      = s.we_n;
	assign o_flash_rst_n     = s.rst_n;
	assign o_flash_vpp_en    = s.vpp_en;
	assign o_flash_addr      = s.addr;
	assign o_flash_dq        = s.wdata;
	assign o_flash_dq_oe     = s.dq_oe;
endmodule

//--- include/afb_pkg.sv
// constants, register map and state codes of the flash bus controller
package afb_pkg;
	localparam int CLK_MHZ     = 40;
	localparam int TMR_W       = 10;
	localparam int ADDR_W      = 20;
	localparam int DATA_W      = 16;
	localparam int BUS_AW      = 5;
	localparam int SYNC_STAGES = 2;

	// pin timing in ns (us for the abort time)
	localparam int T_SETUP_NS  = 0;
	localparam int T_WP_NS     = 50;
	localparam int T_WPH_NS    = 20;
	localparam int T_HOLD_NS   = 0;
	localparam int T_WHGL_NS   = 30;
	localparam int T_RSTREC_NS = 150;
	localparam int T_PLPH_NS   = 100;
	localparam int T_ABORT_US  = 22;
	localparam int T_ACC_NS    = 70;
	localparam int T_HIZ_NS    = 20;
	localparam int T_RDY_OP_NS = T_ACC_NS + 50;
	localparam int T_RDY_QY_NS = T_ACC_NS + 100;

	// least times round up to whole cycles, never below one
	function automatic logic [TMR_W-1:0] ns_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		if (c < 1) begin
			c = 1;
		end
		return TMR_W'(c);
	endfunction

	localparam logic [TMR_W-1:0] C_SETUP  = ns_cyc(T_SETUP_NS);
	localparam logic [TMR_W-1:0] C_WP     = ns_cyc(T_WP_NS);
	localparam logic [TMR_W-1:0] C_HOLD   = ns_cyc(T_HOLD_NS);
	// recovery covers both the high pulse width and the read recovery
	localparam logic [TMR_W-1:0] C_WREC   = (ns_cyc(T_WHGL_NS) > ns_cyc(T_WPH_NS)) ?
	                                        ns_cyc(T_WHGL_NS) : ns_cyc(T_WPH_NS);
	localparam logic [TMR_W-1:0] C_RSTREC = ns_cyc(T_RSTREC_NS);
	localparam logic [TMR_W-1:0] C_PLPH   = ns_cyc(T_PLPH_NS);
	localparam logic [TMR_W-1:0] C_ABORT  = ns_cyc(T_ABORT_US * 1000);
	localparam logic [TMR_W-1:0] C_RD     = ns_cyc(T_ACC_NS) + TMR_W'(SYNC_STAGES);
	localparam logic [TMR_W-1:0] C_HIZ    = ns_cyc(T_HIZ_NS);
	localparam logic [TMR_W-1:0] C_RDY_OP = ns_cyc(T_RDY_OP_NS);
	localparam logic [TMR_W-1:0] C_RDY_QY = ns_cyc(T_RDY_QY_NS);
	localparam logic [TMR_W-1:0] TMR_ONE  = TMR_W'(1);

	// register byte offsets
	localparam logic [BUS_AW-1:0] REG_CTRL     = 5'h00;
	localparam logic [BUS_AW-1:0] REG_ADDR     = 5'h04;
	localparam logic [BUS_AW-1:0] REG_WDATA    = 5'h08;
	localparam logic [BUS_AW-1:0] REG_RDATA    = 5'h0C;
	localparam logic [BUS_AW-1:0] REG_STATUS   = 5'h10;
	localparam logic [BUS_AW-1:0] REG_IRQ_STAT = 5'h14;
	localparam logic [BUS_AW-1:0] REG_IRQ_MASK = 5'h18;

	// control register fields
	localparam int CTRL_GO_READ  = 0;
	localparam int CTRL_GO_WRITE = 1;
	localparam int CTRL_GO_POLL  = 2;
	localparam int CTRL_GO_RESET = 3;
	localparam int CTRL_VPP_REL  = 4;
	localparam int CTRL_CE_CTRL  = 8;
	localparam int CTRL_VPP_REQ  = 9;
	localparam int CTRL_QUERY    = 10;

	// status register fields
	localparam int STAT_BUSY   = 0;
	localparam int STAT_READY  = 1;
	localparam int STAT_VPP    = 2;
	localparam int STAT_OPRUN  = 3;
	localparam int STAT_ERR_LO = 8;

	// interrupt bits
	localparam int IRQ_W    = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR  = 1;

	// flash status word fields
	localparam int READY_BIT = 7;
	localparam int ERR_W     = 4;
	localparam int ERR_B0    = 1;
	localparam int ERR_B1    = 3;
	localparam int ERR_B2    = 4;
	localparam int ERR_B3    = 5;

	typedef enum logic [10:0] {
		ST_BOOT     = 11'h001,
		ST_RST_LOW  = 11'h002,
		ST_RST_REC  = 11'h004,
		ST_IDLE     = 11'h008,
		ST_RD       = 11'h010,
		ST_RD_GAP   = 11'h020,
		ST_WR_SETUP = 11'h040,
		ST_WR_PULSE = 11'h080,
		ST_WR_END   = 11'h100,
		ST_WR_REC   = 11'h200,
		ST_POLL_WT  = 11'h400
	} afb_state_t;
endpackage

//--- include/afb_tmr_if.sv
// interval timer handshake between the controller and its timer
`timescale 1ns/1ps
interface afb_tmr_if #(
	parameter int W = 10
) ();
	logic         load;
	logic [W-1:0] value;
	logic         expired;

	modport ctl (output load, output value, input expired);
	modport tmr (input load, input value, output expired);
endinterface

//--- src/afb_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module afb_sync #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} afb_sync_t;

	afb_sync_t s;
	afb_sync_t next_s;

	always_comb begin
		next_s    = s;
		next_s.s1 = i_d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_q = s.s2;
endmodule

//--- src/afb_timer.sv
// down counter that marks the end of a loaded interval
`timescale 1ns/1ps
module afb_timer
	import afb_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rstn,
	afb_tmr_if.tmr    t
);
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
	} afb_tmr_t;

	afb_tmr_t s;
	afb_tmr_t next_s;

	always_comb begin
		next_s = s;
		if (t.load) begin
			next_s.cnt = t.value;
		end else if (s.cnt != '0) begin
			next_s.cnt = s.cnt - TMR_ONE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign t.expired = (s.cnt == '0);
endmodule

//--- verification/afb_flash_model.sv
// behavioural flash device facing the controller pins
`timescale 1ns/1ps
module afb_flash_model #(
	parameter int BUSY = 300
) (
	input  wire logic        i_clk,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_rst_n,
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_err,
	output logic      [15:0] o_dq
);
	logic        sts_mode = 1'b0;
	logic        armed    = 1'b0;
	logic        req_t    = 1'b0;
	logic        req_q    = 1'b0;
	logic        err      = 1'b0;
	logic [15:0] last_wr  = 16'h0000;
	int          cnt      = 0;
	logic [15:0] val;
	wire logic   wend;

	assign wend = i_ce_n | i_we_n;

	always @(posedge wend) begin
		if (i_rst_n === 1'b1 && armed) begin
			last_wr <= i_dq;
			armed   <= 1'b0;
			err     <= i_err;
			req_t   <= ~req_t;
		end else if (i_rst_n === 1'b1) begin
			armed    <= (i_dq[7:0] == 8'h40);
			sts_mode <= (i_dq[7:0] != 8'hFF);
		end
	end

	// ready drops one clock after the command
	// reset low aborts any running operation
	always @(posedge i_clk) begin
		if (i_rst_n !== 1'b1) begin
			cnt   <= 0;
			req_q <= req_t;
		end else if (req_t != req_q) begin
			req_q <= req_t;
			cnt   <= BUSY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end

	// status and array share one read path
	always_comb begin
		if (sts_mode)
			val = {8'h00, cnt == 0, 2'b00, err, 4'h0};
		else
			val = i_addr[15:0] ^ 16'hA5A5;
	end

	// drives only while selected and out of reset
	// released bus shows the inverse, so a stale value never matches
	assign o_dq = (!i_ce_n && !i_oe_n && i_rst_n) ? val : ~val;
endmodule

//--- verification/afb_ctrl_checker.sv
// pin timing checks on the flash bus controller
`timescale 1ns/1ps
module afb_ctrl_checker (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_avs_read,
	input  wire logic i_avs_write,
	input  wire logic o_avs_waitrequest,
	input  wire logic o_flash_ce_n,
	input  wire logic o_flash_oe_n,
	input  wire logic o_flash_we_n,
	input  wire logic o_flash_rst_n,
	input  wire logic o_flash_dq_oe
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	wire logic pulse;
	assign pulse = !o_flash_ce_n && !o_flash_we_n;

	AST_BUS_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("access not answered in one wait cycle");
	AST_PULSE_MIN: assert property ($rose(pulse) |=> pulse)
		else $error("write pulse shorter than two cycles");
	AST_GAP_MIN: assert property ($fell(pulse) |=> !pulse)
		else $error("write pulse high time too short");
	AST_PULSE_DATA: assert property (pulse |-> o_flash_dq_oe && o_flash_oe_n)
		else $error("write pulse without driven data");
	AST_RST_HOLD: assert property ($fell(o_flash_rst_n) |=> !o_flash_rst_n [*3])
		else $error("flash reset pulse too short");
	AST_RST_PWRUP: assert property ($rose(o_flash_rst_n) |-> !$past(o_flash_rst_n, 4))
		else $error("flash reset released too early");
	AST_WAKE_GAP: assert property ($rose(o_flash_rst_n)
		|-> (o_flash_ce_n && o_flash_we_n) [*6]) else $error("write too soon after reset");
	AST_READ_LEN: assert property ($fell(o_flash_oe_n)
		|-> !o_flash_oe_n [*5] ##1 o_flash_oe_n) else $error("read strobe length wrong");
	AST_OE_WITH_CE: assert property (!o_flash_oe_n |-> !o_flash_ce_n)
		else $error("output enable without chip select");
	AST_WR_TO_RD: assert property ($fell(pulse) |-> o_flash_oe_n [*2])
		else $error("read too soon after write");

	cover property ($rose(pulse));
	cover property ($fell(o_flash_rst_n));
	cover property ($fell(o_flash_oe_n));
endmodule

bind afb_ctrl afb_ctrl_checker chk (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .o_flash_ce_n(o_flash_ce_n),
	.o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n),
	.o_flash_rst_n(o_flash_rst_n), .o_flash_dq_oe(o_flash_dq_oe)
);

//--- verification/tb_top.sv
// self-checking bench for the flash bus controller
`timescale 1ns/1ps
module tb_top
	import afb_pkg::*;
();
	logic              clk    = 1'b0;
	logic              rstn   = 1'b0;
	logic [BUS_AW-1:0] avs_a  = 5'h00;
	logic              avs_r  = 1'b0;
	logic              avs_w  = 1'b0;
	logic [31:0]       avs_wd = 32'h0;
	logic              err_inj = 1'b0;
	logic [31:0]       rdata, rd_q;
	logic              wreq, irq, ce_n, oe_n, we_n, frst_n, vpp, dq_oe;
	logic [ADDR_W-1:0] faddr;
	logic [15:0]       dq_o, fdq, dq;
	int                miscompares = 0;
	int                n_checks = 0;

	assign dq = dq_oe ? dq_o : fdq;

	afb_ctrl uut (
		.i_clk(clk), .i_rstn(rstn), .i_avs_address(avs_a), .i_avs_read(avs_r),
		.i_avs_write(avs_w), .i_avs_writedata(avs_wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .o_irq(irq), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
		.o_flash_we_n(we_n), .o_flash_rst_n(frst_n), .o_flash_vpp_en(vpp),
		.o_flash_addr(faddr), .i_flash_dq(dq), .o_flash_dq(dq_o), .o_flash_dq_oe(dq_oe)
	);
	afb_flash_model fm (
		.i_clk(clk), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(frst_n),
		.i_addr(faddr), .i_dq(dq), .i_err(err_inj), .o_dq(fdq)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	// request held until waitrequest is sampled low at a rising edge, data taken there
	task automatic bus(input logic w, input logic [BUS_AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_w  <= w;
		avs_r  <= !w;
		avs_a  <= a;
		avs_wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20)
			chk("waitrequest", 32'h0, 32'h1);
		rd_q = rdata;
		avs_w <= 1'b0;
		avs_r <= 1'b0;
	endtask

	task automatic wr(input logic [BUS_AW-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [BUS_AW-1:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			rd(REG_STATUS);
			n++;
		end while (rd_q[STAT_BUSY] !== 1'b0 && n < 600);
		if (n >= 600)
			chk("idle", 32'h0, 32'h1);
	endtask

	task automatic go(input logic [31:0] c);
		wr(REG_CTRL, c);
		wait_idle();
	endtask

	task automatic hw_reset;
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		wait_idle();
	endtask

	task automatic t_boot;
		rd(REG_IRQ_STAT);
		chk("boot_done", 32'h1, rd_q & 32'h1);
		wr(REG_IRQ_STAT, 32'h3);
		rd(5'h1C);
		chk("unmapped", 32'h0, rd_q);
	endtask

	task automatic t_read;
		wr(REG_ADDR, 32'h51234);
		rd(REG_ADDR);
		chk("addr_reg", 32'h51234, rd_q);
		go(32'h1);
		rd(REG_RDATA);
		chk("array_word", 32'hB791, rd_q);
	endtask

	// command word then data word, strobe mode chosen by ce, query wait with errors
	task automatic t_prog(input logic [31:0] ce, input logic e);
		logic [31:0] q;
		q = e ? 32'h400 : 32'h0;
		wr(REG_WDATA, 32'h40);
		go(32'h202 | ce);
		err_inj <= e;
		wr(REG_WDATA, 32'hC3A5);
		go(32'h2 | ce);
		chk("written", 32'hC3A5, {16'h0, fm.last_wr});
		rd(REG_STATUS);
		chk("run_vpp", 32'hC, rd_q & 32'hC);
		chk("vpp_pin", 32'h1, vpp);
		go(32'h4 | q | ce);
		rd(REG_CTRL);
		chk("ctrl_cfg", q | ce, rd_q);
		rd(REG_STATUS);
		chk("status", e ? 32'h406 : 32'h2, rd_q & 32'hF0F);
		chk("vpp_kept", {31'h0, e}, vpp);
		rd(REG_RDATA);
		chk("sts_word", e ? 32'h90 : 32'h80, rd_q);
	endtask

	task automatic t_irq;
		wr(REG_IRQ_MASK, 32'h0);
		@(negedge clk);
		chk("irq_masked", 32'h0, irq);
		wr(REG_IRQ_MASK, 32'h2);
		@(negedge clk);
		chk("irq_err", 32'h1, irq);
		wr(REG_IRQ_STAT, 32'h2);
		@(negedge clk);
		chk("irq_clear", 32'h0, irq);
		go(32'h10);
		rd(REG_STATUS);
		chk("vpp_off", 32'h0, rd_q & 32'h4);
		chk("vpp_pin_off", 32'h0, vpp);
		err_inj <= 1'b0;
	endtask

	task automatic t_rst(input logic run);
		int n;
		n = 0;
		if (run) begin
			wr(REG_WDATA, 32'h40);
			go(32'h202);
			wr(REG_WDATA, 32'hBEEF);
			go(32'h2);
		end
		wr(REG_CTRL, 32'h8);
		do begin
			@(negedge clk);
			n++;
		end while (frst_n !== 1'b0 && n < 20);
		@(negedge clk);
		chk("op_left", 32'h0, fm.cnt);
		n = 1;
		while (frst_n === 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("rst_low", run ? C_ABORT : C_PLPH, n);
		wait_idle();
		rd(REG_STATUS);
		chk("run_vpp", 32'h0, rd_q & 32'hC);
		chk("vpp_rst", 32'h0, vpp);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		hw_reset();
		t_boot();
		t_read();
		t_prog(32'h0, 1'b0);
		t_prog(32'h100, 1'b1);
		t_irq();
		t_rst(1'b0);
		t_rst(1'b1);
		hw_reset();
		t_boot();
		report_and_stop();
	end
endmodule
